// ---- verilog/two_channel_dma_control.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "dma_ctrl_defines.svh"

module two_channel_dma_control
  import dma_ctrl_pkg::*;
(
  input wire logic I_REF_CLK,
  input wire logic I_NRST,
  input wire logic [7:0] I_IO_ADDR,
  input wire logic I_IO_WR,
  input wire logic I_IO_RD,
  input wire logic [7:0] I_IO_WDATA,
  output logic [7:0] O_IO_RDATA,
  input wire logic I_NMI,
  input wire logic I_REQ0,
  input wire logic I_REQ1,
  output logic O_IRQ,
  output logic O_BUS_HOLD,
  output logic O_CMD_VALID,
  input wire logic I_CMD_READY,
  output logic [4:0] O_CMD,
  output logic [19:0] O_CH1_MEM_ADDR,
  output logic [15:0] O_CH1_IO_ADDR,
  output logic [7:0] O_CH1_IO_TOP,
  output logic [1:0] O_MEM_WAIT,
  output logic [1:0] O_IO_WAIT
);

  // ****************************************
  // registers
  // ****************************************
  logic ch0_en_r, ch1_en_r, main_en_r;
  logic ch0_irq_en_r, ch1_irq_en_r;
  logic [7:0] ch0_mode_r, wait_ctrl_r, io_top_r;
  logic [15:0] io_addr_r, ch0_count_r, ch1_count_r;
  logic [19:0] mem_addr_r;
  logic req0_d_r, req1_d_r, edge0_r, edge1_r;
  state_type state_r, state_nxt;

  logic wr_status, guard0_open, guard1_open;
  logic go0, go1, go_any, issue, pick1, term0, term1;
  logic ch0_memmem, ch0_has_io;
  sel_type src0, dst0, ch1_src, ch1_dst;
  logic buf_in_ready;
  cmd_type cmd_in;

  function automatic logic hit(input logic [7:0] ofs);
    hit = I_IO_WR && (I_IO_ADDR == ofs);
  endfunction

  // one byte moved: the count steps down by one
  function automatic logic [15:0] count_down(input logic [15:0] cnt);
    count_down = cnt - 16'h0001;
  endfunction

  function automatic logic last_byte(input logic [15:0] cnt);
    last_byte = (cnt == 16'h0001);
  endfunction

  // channel 1 memory side: the step bit picks the direction
  function automatic sel_type mem_step(input logic down);
    mem_step = down ? SEL_MEM_DEC : SEL_MEM_INC;
  endfunction

  function automatic logic rise(input logic pin, input logic prev);
    rise = pin && !prev;
  endfunction

  // level sense follows the pin; edge sense waits for a latched rise
  function automatic logic req_seen(input logic edge_sense, input logic latched, input logic pin);
    req_seen = edge_sense ? latched : pin;
  endfunction

  // ****************************************
  // channel decode
  // ****************************************
  assign src0 = sel_type'(ch0_mode_r[`FLD_CH0_SRC]);
  assign dst0 = sel_type'(ch0_mode_r[`FLD_CH0_DST]);
  assign ch0_has_io = (src0 == SEL_IO_FIX) || (dst0 == SEL_IO_FIX);
  assign ch0_memmem = !ch0_has_io;
  // channel 1 direction maps onto the common step code
  assign ch1_src = wait_ctrl_r[`BIT_CH1_DIR] ? SEL_IO_FIX : mem_step(wait_ctrl_r[`BIT_CH1_STEP]);
  assign ch1_dst = wait_ctrl_r[`BIT_CH1_DIR] ? mem_step(wait_ctrl_r[`BIT_CH1_STEP]) : SEL_IO_FIX;

  // ****************************************
  // request sensing
  // ****************************************
  always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      req0_d_r <= 1'b0;
      req1_d_r <= 1'b0;
    end else begin
      req0_d_r <= I_REQ0;
      req1_d_r <= I_REQ1;
    end
  end

  // set wins over consumption, so an edge in the issue cycle is kept
  always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      edge0_r <= 1'b0;
      edge1_r <= 1'b0;
    end else begin
      if (rise(I_REQ0, req0_d_r))
        edge0_r <= 1'b1;
      else if (issue && !pick1)
        edge0_r <= 1'b0;
      if (rise(I_REQ1, req1_d_r))
        edge1_r <= 1'b1;
      else if (issue && pick1)
        edge1_r <= 1'b0;
    end
  end

  logic req0_ok, req1_ok;
  assign req0_ok = req_seen(wait_ctrl_r[`BIT_SENSE_CH0], edge0_r, I_REQ0);
  assign req1_ok = req_seen(wait_ctrl_r[`BIT_SENSE_CH1], edge1_r, I_REQ1);

  // ****************************************
  // transfer engine
  // ****************************************
  // io-to-io is an illegal setting; it simply never starts
  assign go0 = ch0_en_r && main_en_r && (ch0_count_r != 16'h0000)
    && !(src0 == SEL_IO_FIX && dst0 == SEL_IO_FIX)
    && (ch0_memmem || req0_ok);
  assign go1 = ch1_en_r && main_en_r && (ch1_count_r != 16'h0000) && req1_ok;
  assign go_any = go0 || go1;
  assign pick1 = !go0;
  assign issue = (state_r == ST_XFER) && go_any && buf_in_ready;
  assign term0 = (issue && !pick1 && last_byte(ch0_count_r))
    || (ch0_en_r && ch0_count_r == 16'h0000);
  assign term1 = (issue && pick1 && last_byte(ch1_count_r))
    || (ch1_en_r && ch1_count_r == 16'h0000);
  assign cmd_in = pick1 ? {1'b1, ch1_src, ch1_dst} : {1'b0, src0, dst0};

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: begin
        if (go_any)
          state_nxt = ST_XFER;
      end
      ST_XFER: begin
        // cycle steal returns the bus for two cycles (give, then idle) after every channel 0 memory-to-memory byte
        if (issue && !pick1 && ch0_memmem && !ch0_mode_r[`BIT_MEM_TIMING])
          state_nxt = ST_GIVE;
        else if (!go_any)
          state_nxt = ST_IDLE;
      end
      ST_GIVE: begin
        state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST)
      state_r <= ST_IDLE;
    else
      state_r <= state_nxt;
  end

  // burst stays in xfer while the count lasts; a full buffer holds the bus too
  assign O_BUS_HOLD = (state_r == ST_XFER);

  // ****************************************
  // status and enables
  // ****************************************
  assign wr_status = hit(`OFS_STATUS);
  assign guard0_open = wr_status && !I_IO_WDATA[`BIT_CH0_GUARD];
  assign guard1_open = wr_status && !I_IO_WDATA[`BIT_CH1_GUARD];

  // a fresh guarded write outranks a termination in the same cycle
  always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      ch0_en_r <= 1'b0;
      ch1_en_r <= 1'b0;
    end else begin
      if (guard0_open)
        ch0_en_r <= I_IO_WDATA[`BIT_CH0_EN];
      else if (term0)
        ch0_en_r <= 1'b0;
      if (guard1_open)
        ch1_en_r <= I_IO_WDATA[`BIT_CH1_EN];
      else if (term1)
        ch1_en_r <= 1'b0;
    end
  end

  // nmi beats a simultaneous restart so the service routine starts quiet
  always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST)
      main_en_r <= 1'b0;
    else if (I_NMI)
      main_en_r <= 1'b0;
    else if ((guard0_open && I_IO_WDATA[`BIT_CH0_EN]) || (guard1_open && I_IO_WDATA[`BIT_CH1_EN]))
      main_en_r <= 1'b1;
  end

  always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      ch0_irq_en_r <= 1'b0;
      ch1_irq_en_r <= 1'b0;
    end else if (wr_status) begin
      ch0_irq_en_r <= I_IO_WDATA[`BIT_CH0_IRQ_EN];
      ch1_irq_en_r <= I_IO_WDATA[`BIT_CH1_IRQ_EN];
    end
  end

  assign O_IRQ = (!ch0_en_r && ch0_irq_en_r) || (!ch1_en_r && ch1_irq_en_r);

  // ****************************************
  // mode and wait control
  // ****************************************
  always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      ch0_mode_r <= `RST_CH0_MODE;
      wait_ctrl_r <= `RST_WAIT_CTRL;
      io_top_r <= `RST_IO_TOP;
    end else begin
      if (hit(`OFS_CH0_MODE))
        ch0_mode_r <= {2'b00, I_IO_WDATA[`FLD_CH0_MODE_WR], 1'b0};
      if (hit(`OFS_WAIT_CTRL))
        wait_ctrl_r <= I_IO_WDATA;
      if (hit(`OFS_CH1_IO_TOP))
        io_top_r <= I_IO_WDATA;
    end
  end

  assign O_MEM_WAIT = wait_ctrl_r[`FLD_MEM_WAIT];
  assign O_IO_WAIT = wait_ctrl_r[`FLD_IO_WAIT];
  assign O_CH1_IO_TOP = io_top_r;
  assign O_CH1_IO_ADDR = io_addr_r;
  assign O_CH1_MEM_ADDR = mem_addr_r;

  // ****************************************
  // counts and addresses
  // ****************************************
  // contents undefined after reset on real parts; cleared here for determinism
  always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      ch0_count_r <= 16'h0000;
      ch1_count_r <= 16'h0000;
    end else begin
      if (hit(`OFS_CH0_COUNT_LOW))
        ch0_count_r[7:0] <= I_IO_WDATA;
      else if (hit(`OFS_CH0_COUNT_HIGH))
        ch0_count_r[15:8] <= I_IO_WDATA;
      else if (issue && !pick1)
        ch0_count_r <= count_down(ch0_count_r);
      if (hit(`OFS_CH1_COUNT_LOW))
        ch1_count_r[7:0] <= I_IO_WDATA;
      else if (hit(`OFS_CH1_COUNT_HIGH))
        ch1_count_r[15:8] <= I_IO_WDATA;
      else if (issue && pick1)
        ch1_count_r <= count_down(ch1_count_r);
    end
  end

  always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      mem_addr_r <= 20'h00000;
      io_addr_r <= 16'h0000;
    end else begin
      if (hit(`OFS_CH1_MEM_LOW))
        mem_addr_r[7:0] <= I_IO_WDATA;
      else if (hit(`OFS_CH1_MEM_HIGH))
        mem_addr_r[15:8] <= I_IO_WDATA;
      else if (hit(`OFS_CH1_MEM_TOP))
        mem_addr_r[19:16] <= I_IO_WDATA[3:0];
      else if (issue && pick1)
        mem_addr_r <= wait_ctrl_r[`BIT_CH1_STEP] ? mem_addr_r - 20'h00001 : mem_addr_r + 20'h00001;
      if (hit(`OFS_CH1_IO_LOW))
        io_addr_r[7:0] <= I_IO_WDATA;
      if (hit(`OFS_CH1_IO_HIGH))
        io_addr_r[15:8] <= I_IO_WDATA;
    end
  end

  // ****************************************
  // command buffer
  // ****************************************
  // two entries let a stalled consumer absorb two bytes without loss
  cmd_type buf_mem [0:`BUF_DEPTH-1];
  logic buf_wr_r, buf_rd_r;
  logic [1:0] buf_cnt_r;
  logic buf_pop;

  assign buf_in_ready = (buf_cnt_r != 2'd2);
  assign O_CMD_VALID = (buf_cnt_r != 2'd0);
  assign buf_pop = O_CMD_VALID && I_CMD_READY;
  assign O_CMD = buf_mem[buf_rd_r];

  always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      buf_wr_r <= 1'b0;
      buf_rd_r <= 1'b0;
      buf_cnt_r <= 2'd0;
      buf_mem[0] <= 5'h00;
      buf_mem[1] <= 5'h00;
    end else begin
      if (issue) begin
        buf_mem[buf_wr_r] <= cmd_in;
        buf_wr_r <= !buf_wr_r;
      end
      if (buf_pop)
        buf_rd_r <= !buf_rd_r;
      if (issue && !buf_pop)
        buf_cnt_r <= buf_cnt_r + 2'd1;
      else if (buf_pop && !issue)
        buf_cnt_r <= buf_cnt_r - 2'd1;
    end
  end

  // ****************************************
  // read back
  // ****************************************
  always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST)
      O_IO_RDATA <= 8'h00;
    else if (I_IO_RD) begin
      unique case (I_IO_ADDR)
        `OFS_CH0_COUNT_LOW: O_IO_RDATA <= ch0_count_r[7:0];
        `OFS_CH0_COUNT_HIGH: O_IO_RDATA <= ch0_count_r[15:8];
        `OFS_CH1_MEM_LOW: O_IO_RDATA <= mem_addr_r[7:0];
        `OFS_CH1_MEM_HIGH: O_IO_RDATA <= mem_addr_r[15:8];
        `OFS_CH1_MEM_TOP: O_IO_RDATA <= {4'h0, mem_addr_r[19:16]};
        `OFS_CH1_IO_LOW: O_IO_RDATA <= io_addr_r[7:0];
        `OFS_CH1_IO_HIGH: O_IO_RDATA <= io_addr_r[15:8];
        `OFS_CH1_IO_TOP: O_IO_RDATA <= io_top_r;
        `OFS_CH1_COUNT_LOW: O_IO_RDATA <= ch1_count_r[7:0];
        `OFS_CH1_COUNT_HIGH: O_IO_RDATA <= ch1_count_r[15:8];
        `OFS_STATUS: O_IO_RDATA <= {ch1_en_r, ch0_en_r, 2'b11, ch1_irq_en_r, ch0_irq_en_r, 1'b0, main_en_r};
        `OFS_CH0_MODE: O_IO_RDATA <= ch0_mode_r;
        `OFS_WAIT_CTRL: O_IO_RDATA <= wait_ctrl_r;
        default: O_IO_RDATA <= 8'h00;
      endcase
    end
  end

endmodule

`default_nettype wire

// ---- verilog/dma_ctrl_defines.svh ----
`ifndef DMA_CTRL_DEFINES_SVH
`define DMA_CTRL_DEFINES_SVH

`define OFS_CH0_COUNT_LOW 8'h26
`define OFS_CH0_COUNT_HIGH 8'h27
`define OFS_CH1_MEM_LOW 8'h28
`define OFS_CH1_MEM_HIGH 8'h29
`define OFS_CH1_MEM_TOP 8'h2a
`define OFS_CH1_IO_LOW 8'h2b
`define OFS_CH1_IO_HIGH 8'h2c
`define OFS_CH1_IO_TOP 8'h2d
`define OFS_CH1_COUNT_LOW 8'h2e
`define OFS_CH1_COUNT_HIGH 8'h2f
`define OFS_STATUS 8'h30
`define OFS_CH0_MODE 8'h31
`define OFS_WAIT_CTRL 8'h32

`define BIT_CH1_EN 7
`define BIT_CH0_EN 6
`define BIT_CH1_GUARD 5
`define BIT_CH0_GUARD 4
`define BIT_CH1_IRQ_EN 3
`define BIT_CH0_IRQ_EN 2
`define BIT_MAIN_EN 0
`define BIT_MEM_TIMING 1
`define BIT_SENSE_CH0 3
`define BIT_SENSE_CH1 2
`define BIT_CH1_DIR 1
`define BIT_CH1_STEP 0
`define FLD_CH0_DST 5:4
`define FLD_CH0_SRC 3:2
`define FLD_CH0_MODE_WR 5:1
`define FLD_MEM_WAIT 7:6
`define FLD_IO_WAIT 5:4

`define RST_CH0_MODE 8'h00
`define RST_WAIT_CTRL 8'hf0
`define RST_IO_TOP 8'h00

`define BUF_DEPTH 2

`endif

// ---- verilog/dma_ctrl_pkg.sv ----
`default_nettype none
package dma_ctrl_pkg;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_XFER = 2'b01,
    ST_GIVE = 2'b10
  } state_type;

  // common address step code for source and destination sides
  typedef enum logic [1:0] {
    SEL_MEM_INC = 2'b00,
    SEL_MEM_DEC = 2'b01,
    SEL_MEM_FIX = 2'b10,
    SEL_IO_FIX = 2'b11
  } sel_type;

  // command word: channel, source step, destination step
  typedef logic [4:0] cmd_type;

endpackage

`default_nettype wire

// ---- bench/dma_cmd_sink.sv ----
`timescale 1ns/10ps
`default_nettype none
// ****
// command consumer on the far side
// ****
module dma_cmd_sink (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_stall,
  input wire logic i_valid,
  input wire logic [4:0] i_cmd,
  output logic o_ready,
  output logic [7:0] o_count,
  output logic [4:0] o_last
);
  // ready drops only on request, so the bench can fill the buffer
  assign o_ready = !i_stall;
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_count <= 8'h00;
      o_last <= 5'h00;
    end else if (i_valid && o_ready) begin
      o_count <= o_count + 8'h01;
      o_last <= i_cmd;
    end
  end
endmodule
`default_nettype wire

// ---- bench/two_channel_dma_control_assertions.sv ----
`timescale 1ns/10ps
`default_nettype none
// ****
// port checks
// ****
module two_channel_dma_control_checker (
  input wire logic I_REF_CLK,
  input wire logic I_NRST,
  input wire logic [7:0] I_IO_ADDR,
  input wire logic I_IO_WR,
  input wire logic I_IO_RD,
  input wire logic [7:0] I_IO_WDATA,
  input wire logic [7:0] O_IO_RDATA,
  input wire logic I_NMI,
  input wire logic I_CMD_READY,
  input wire logic O_IRQ,
  input wire logic O_BUS_HOLD,
  input wire logic O_CMD_VALID,
  input wire logic [4:0] O_CMD,
  input wire logic [19:0] O_CH1_MEM_ADDR,
  input wire logic [15:0] O_CH1_IO_ADDR,
  input wire logic [7:0] O_CH1_IO_TOP,
  input wire logic [1:0] O_MEM_WAIT,
  input wire logic [1:0] O_IO_WAIT
);
  default clocking @(posedge I_REF_CLK); endclocking
  default disable iff (!I_NRST);
  a_reset_vals:
  assert property ($rose(I_NRST) |-> !O_IRQ && !O_BUS_HOLD && !O_CMD_VALID && O_MEM_WAIT == 2'b11
    && O_IO_WAIT == 2'b11 && O_CH1_IO_TOP == 8'h00) else $error("reset values wrong");
  a_guard_read:
  assert property (I_IO_RD && I_IO_ADDR == 8'h30 |=> O_IO_RDATA[5:4] == 2'b11 && !O_IO_RDATA[1])
    else $error("guard bits not read as ones");
  a_irq_state:
  assert property (I_IO_RD && I_IO_ADDR == 8'h30 && !I_IO_WR && !O_BUS_HOLD && !O_CMD_VALID
    |=> O_IRQ == ((!O_IO_RDATA[7] && O_IO_RDATA[3]) || (!O_IO_RDATA[6] && O_IO_RDATA[2])))
    else $error("interrupt request disagrees with enables");
  a_nmi_halt:
  assert property (I_NMI |-> ##2 !$rose(O_CMD_VALID)) else $error("byte issued after nmi");
  a_no_io_io:
  assert property (O_CMD_VALID && !O_CMD[4] |-> O_CMD[3:0] != 4'hf) else $error("io to io issued");
  a_ch1_dir:
  assert property (O_CMD_VALID && O_CMD[4] |-> (O_CMD[3:2] == 2'b11 && !O_CMD[1])
    || (O_CMD[1:0] == 2'b11 && !O_CMD[3])) else $error("bad channel 1 step codes");
  a_cmd_hold:
  assert property (O_CMD_VALID && !I_CMD_READY |=> O_CMD_VALID && $stable(O_CMD))
    else $error("command dropped while stalled");
  a_wait_write:
  assert property (I_IO_WR && I_IO_ADDR == 8'h32 |=> {O_MEM_WAIT, O_IO_WAIT} == $past(I_IO_WDATA[7:4]))
    else $error("wait fields not written");
  a_top_write:
  assert property (I_IO_WR && I_IO_ADDR == 8'h2d |=> O_CH1_IO_TOP == $past(I_IO_WDATA))
    else $error("top byte not written");
  a_io_addr_fixed:
  assert property (!(I_IO_WR && (I_IO_ADDR == 8'h2b || I_IO_ADDR == 8'h2c)) |=> $stable(O_CH1_IO_ADDR))
    else $error("channel 1 io address moved");
  a_mem_addr_kept:
  assert property (!I_IO_WR && !O_BUS_HOLD |=> $stable(O_CH1_MEM_ADDR))
    else $error("channel 1 memory address moved while idle");
endmodule
bind two_channel_dma_control two_channel_dma_control_checker i_checker (.I_REF_CLK, .I_NRST, .I_IO_ADDR,
  .I_IO_WR, .I_IO_RD, .I_IO_WDATA, .O_IO_RDATA, .I_NMI, .I_CMD_READY, .O_IRQ, .O_BUS_HOLD, .O_CMD_VALID,
  .O_CMD, .O_CH1_MEM_ADDR, .O_CH1_IO_ADDR, .O_CH1_IO_TOP, .O_MEM_WAIT, .O_IO_WAIT);
`default_nettype wire

// ---- bench/tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
// ****
// bench
// ****
module tb_top;
  logic clk = 0, nrst = 0, wrs = 0, rds = 0, nmi = 0, req0 = 0, req1 = 0, stall = 0, hq;
  logic [7:0] addr = 8'h00, wdata = 8'h00, tot = 8'h00, k, rises;
  logic [7:0] exp1 [4] = '{8'h13, 8'h17, 8'h1c, 8'h1d};
  wire [7:0] rdata, cnt;
  wire [4:0] cmd, last;
  wire [19:0] maddr;
  wire [15:0] ioaddr;
  wire irq, hold, cvalid, cready;
  int num_errors = 0, n_compared = 0;
  initial forever #10 clk = ~clk;
  two_channel_dma_control i_two_channel_dma_control (.I_REF_CLK(clk), .I_NRST(nrst), .I_IO_ADDR(addr),
    .I_IO_WR(wrs), .I_IO_RD(rds), .I_IO_WDATA(wdata), .O_IO_RDATA(rdata), .I_NMI(nmi), .I_REQ0(req0),
    .I_REQ1(req1), .O_IRQ(irq), .O_BUS_HOLD(hold), .O_CMD_VALID(cvalid), .I_CMD_READY(cready), .O_CMD(cmd),
    .O_CH1_MEM_ADDR(maddr), .O_CH1_IO_ADDR(ioaddr), .O_CH1_IO_TOP(), .O_MEM_WAIT(), .O_IO_WAIT());
  dma_cmd_sink i_dma_cmd_sink (.i_clk(clk), .i_nrst(nrst), .i_stall(stall), .i_valid(cvalid), .i_cmd(cmd),
    .o_ready(cready), .o_count(cnt), .o_last(last));
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    n_compared++;
    if (s !== e) begin
      num_errors++;
      $display("mismatch at %0t: got %h want %h", $time, s, e);
    end
  endtask
  task automatic end_of_test;
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wrs = 1;
    @(negedge clk);
    wrs = 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    addr = a;
    rds = 1;
    @(negedge clk);
    rds = 0;
    chk(rdata, e);
  endtask
  // bounded wait for n more accepted bytes, counting bus grabs
  task automatic go(input logic [7:0] n);
    int w;
    w = 0;
    rises = 8'h00;
    hq = hold;
    while (cnt !== tot + n) begin
      @(negedge clk);
      if (hold && !hq) rises++;
      hq = hold;
      w++;
      if (w > 300) begin
        chk(cnt, tot + n);
        end_of_test;
      end
    end
    tot = tot + n;
  endtask
  task automatic s_reset;
    rd(8'h30, 8'h30);
    rd(8'h31, 8'h00);
    rd(8'h32, 8'hf0);
    rd(8'h2d, 8'h00);
    wr(8'h30, 8'hff);
    rd(8'h30, 8'h3c);
    chk({7'h00, irq}, 8'h01);
  endtask
  task automatic s_burst;
    wr(8'h26, 8'h04);
    wr(8'h31, 8'he7);
    rd(8'h31, 8'h26);
    stall = 1;
    wr(8'h30, 8'h4c);
    repeat (10) @(negedge clk);
    chk({6'h00, cvalid, hold}, 8'h03);
    chk(cnt, tot);
    stall = 0;
    go(8'h04);
    chk(rises, 8'h00);
    chk({3'b000, last}, 8'h06);
    rd(8'h30, 8'h3d);
    chk({7'h00, cvalid}, 8'h00);
  endtask
  task automatic s_steal;
    wr(8'h26, 8'h03);
    wr(8'h31, 8'h18);
    wr(8'h30, 8'h4c);
    go(8'h03);
    chk(rises, 8'h03);
    chk({3'b000, last}, 8'h09);
    wr(8'h26, 8'h02);
    wr(8'h31, 8'h0e);
    wr(8'h30, 8'h4c);
    repeat (20) @(negedge clk);
    chk(cnt, tot);
    req0 = 1;
    go(8'h02);
    chk(last, 5'h0c);
    wr(8'h26, 8'h01);
    wr(8'h31, 8'h3c);
    wr(8'h30, 8'h4c);
    repeat (30) @(negedge clk);
    chk(cnt, tot);
    req0 = 0;
    wr(8'h30, 8'h0c);
  endtask
  task automatic s_halt;
    wr(8'h26, 8'h04);
    wr(8'h31, 8'h00);
    wr(8'h30, 8'h4c);
    k = tot;
    go(8'h01);
    nmi = 1;
    @(negedge clk);
    nmi = 0;
    rd(8'h30, 8'h7c);
    repeat (10) @(negedge clk);
    chk(cnt, tot);
    wr(8'h30, 8'h0c);
    rd(8'h30, 8'h3c);
    wr(8'h30, 8'h4c);
    tot = k;
    go(8'h04);
    rd(8'h30, 8'h3d);
  endtask
  task automatic s_ch1;
    wr(8'h28, 8'h10);
    wr(8'h2b, 8'ha5);
    wr(8'h2c, 8'h3c);
    req1 = 1;
    for (int m = 0; m < 4; m++) begin
      wr(8'h2e, 8'h01);
      wr(8'h32, {m[1:0], ~m[1:0], 2'b00, m[1:0]});
      wr(8'h30, 8'h8c);
      go(8'h01);
      chk({3'b000, last}, exp1[m]);
    end
    chk(maddr[7:0], 8'h10);
    // output device with zero-wait cycles needs edge sensing
    wr(8'h32, 8'h04);
    wr(8'h2e, 8'h02);
    wr(8'h30, 8'h8c);
    repeat (20) @(negedge clk);
    chk(cnt, tot);
    req1 = 0;
    @(negedge clk);
    req1 = 1;
    go(8'h01);
    repeat (10) @(negedge clk);
    chk(cnt, tot);
    req1 = 0;
    chk(maddr[7:0], 8'h11);
    chk(ioaddr[7:0], 8'ha5);
    chk(ioaddr[15:8], 8'h3c);
    wr(8'h2d, 8'h5a);
    rd(8'h2d, 8'h5a);
  endtask
  initial begin
    repeat (4) @(negedge clk);
    nrst = 1;
    s_reset;
    s_burst;
    s_steal;
    s_halt;
    s_ch1;
    end_of_test;
  end
endmodule
`default_nettype wire
